// [mhc_regs.svh]
// register offsets, field positions, reset values and timing for mhc_host
`ifndef MHC_REGS_SVH
`define MHC_REGS_SVH

`define MHC_CTRL_OFS     8'h00
`define MHC_STAT_OFS     8'h04
`define MHC_TXD_OFS      8'h08
`define MHC_RXD_OFS      8'h0C

`define MHC_CTRL_TX      0
`define MHC_CTRL_KICK    1
`define MHC_CTRL_UNCLAMP 2
`define MHC_CTRL_W       3
`define MHC_CTRL_RST     3'h2

`define MHC_ST_CAR       0
`define MHC_ST_SUPV      1
`define MHC_ST_CAREVT    2
`define MHC_ST_TXBUSY    3
`define MHC_ST_RXVAL     4
`define MHC_ST_RXERR     5
`define MHC_ST_SUPVLVL   6
`define MHC_ST_W         7

`define MHC_CLK_MHZ      250
`define MHC_KICK_LOW_NS  1000
`define MHC_KICK_MIN_NS  500
`define MHC_KICK_PER_MS  100
`define MHC_BAUD         1200
`define MHC_CLK_HZ       250000000
`define MHC_KICK_LOW_CYC ((`MHC_KICK_MIN_NS * `MHC_CLK_MHZ + 999) / 1000)
`define MHC_KICK_PER_CYC (`MHC_KICK_PER_MS * `MHC_CLK_MHZ * 1000)
`define MHC_BIT_CYC      ((`MHC_CLK_HZ + `MHC_BAUD - 1) / `MHC_BAUD)

`define MHC_FRAME_LAST   4'hA
`define MHC_RXBIT_LAST   4'h9

`endif

// [mhc_pkg.sv]
// shared types for the modem host controller
package mhc_pkg;

	typedef struct packed {
		logic dir_sel;
		logic kick_n;
		logic serial_out_pin;
	} mhc_pins_t;

	typedef struct packed {
		logic [7:0] data;
		logic       err;
	} mhc_rxbyte_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'h0,
		TX_SEND = 2'h1
	} mhc_tx_st_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'h0,
		RX_START = 2'h1,
		RX_DATA  = 2'h3
	} mhc_rx_st_t;

endpackage : mhc_pkg

// [mhc_uart.sv]
// asynchronous byte transmitter and receiver, start + 8 data + odd parity + stop
`timescale 1ns/100ps
`include "mhc_regs.svh"

module mhc_uart #(
	parameter int unsigned BIT_CYC = `MHC_BIT_CYC
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 tx_start,
	input  wire logic [7:0]           tx_byte,
	input  wire logic                 rx_in,
	output logic                      txd,
	output logic                      tx_busy,
	output logic                      rx_valid,
	output mhc_pkg::mhc_rxbyte_t      rx_byte
);
	import mhc_pkg::*;

	localparam logic [31:0] BIT_LAST  = 32'(BIT_CYC - 1);
	localparam logic [31:0] HALF_LAST = 32'(BIT_CYC / 2 - 1);

	mhc_tx_st_t  tx_st_q,  tx_st_d;
	logic [31:0] tx_cnt_q, tx_cnt_d;
	logic [3:0]  tx_idx_q, tx_idx_d;
	logic [10:0] tx_sh_q,  tx_sh_d;
	logic        txd_q,    txd_d;

	mhc_rx_st_t  rx_st_q,  rx_st_d;
	logic [31:0] rx_cnt_q, rx_cnt_d;
	logic [3:0]  rx_idx_q, rx_idx_d;
	logic [9:0]  rx_sh_q,  rx_sh_d;
	logic        rx_val_q, rx_val_d;
	mhc_rxbyte_t rx_b_q,   rx_b_d;

	// transmit: line idles high, bits leave lsb first
	always_comb begin
		tx_st_d  = tx_st_q;
		tx_cnt_d = tx_cnt_q;
		tx_idx_d = tx_idx_q;
		tx_sh_d  = tx_sh_q;
		txd_d    = txd_q;
		case (tx_st_q)
			TX_IDLE: begin
				txd_d = 1'b1;
				if (tx_start) begin
					tx_sh_d  = {1'b1, ~^tx_byte, tx_byte, 1'b0};
					tx_cnt_d = 32'h0;
					tx_idx_d = 4'h0;
					txd_d    = 1'b0;
					tx_st_d  = TX_SEND;
				end
			end
			TX_SEND: begin
				if (tx_cnt_q == BIT_LAST) begin // every bit lasts BIT_CYC [RULE9]
					tx_cnt_d = 32'h0;
					if (tx_idx_q == `MHC_FRAME_LAST) begin
						txd_d   = 1'b1;
						tx_st_d = TX_IDLE;
					end else begin
						tx_idx_d = tx_idx_q + 4'h1;
						tx_sh_d  = {1'b1, tx_sh_q[10:1]};
						txd_d    = tx_sh_q[1];
					end
				end else begin
					tx_cnt_d = tx_cnt_q + 32'h1;
				end
			end
			default: tx_st_d = TX_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_q  <= TX_IDLE;
			tx_cnt_q <= 32'h0;
			tx_idx_q <= 4'h0;
			tx_sh_q  <= 11'h7FF;
			txd_q    <= 1'b1;
		end else begin
			tx_st_q  <= tx_st_d;
			tx_cnt_q <= tx_cnt_d;
			tx_idx_q <= tx_idx_d;
			tx_sh_q  <= tx_sh_d;
			txd_q    <= txd_d;
		end
	end

	// receive: start bit rechecked at mid-bit so a glitch is not a frame
	always_comb begin
		logic [9:0] sh;
		sh       = {rx_in, rx_sh_q[9:1]};
		rx_st_d  = rx_st_q;
		rx_cnt_d = rx_cnt_q;
		rx_idx_d = rx_idx_q;
		rx_sh_d  = rx_sh_q;
		rx_val_d = 1'b0;
		rx_b_d   = rx_b_q;
		case (rx_st_q)
			RX_IDLE: begin
				rx_cnt_d = 32'h0;
				if (!rx_in) begin
					rx_st_d = RX_START;
				end
			end
			RX_START: begin
				if (rx_cnt_q == HALF_LAST) begin
					rx_cnt_d = 32'h0;
					rx_idx_d = 4'h0;
					rx_st_d  = rx_in ? RX_IDLE : RX_DATA;
				end else begin
					rx_cnt_d = rx_cnt_q + 32'h1;
				end
			end
			RX_DATA: begin
				if (rx_cnt_q == BIT_LAST) begin
					rx_cnt_d = 32'h0;
					rx_sh_d  = sh;
					rx_idx_d = rx_idx_q + 4'h1;
					if (rx_idx_q == `MHC_RXBIT_LAST) begin
						rx_val_d    = 1'b1;
						rx_b_d.data = sh[7:0];
						rx_b_d.err  = (sh[8] != ~^sh[7:0]) | ~sh[9];
						rx_st_d     = RX_IDLE;
					end
				end else begin
					rx_cnt_d = rx_cnt_q + 32'h1;
				end
			end
			default: rx_st_d = RX_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_q  <= RX_IDLE;
			rx_cnt_q <= 32'h0;
			rx_idx_q <= 4'h0;
			rx_sh_q  <= 10'h0;
			rx_val_q <= 1'b0;
			rx_b_q   <= '0;
		end else begin
			rx_st_q  <= rx_st_d;
			rx_cnt_q <= rx_cnt_d;
			rx_idx_q <= rx_idx_d;
			rx_sh_q  <= rx_sh_d;
			rx_val_q <= rx_val_d;
			rx_b_q   <= rx_b_d;
		end
	end

	assign txd      = txd_q;
	assign tx_busy  = (tx_st_q != TX_IDLE);
	assign rx_valid = rx_val_q;
	assign rx_byte  = rx_b_q;

endmodule : mhc_uart

// [mhc_host.sv]
// host-side controller for a power line modem with an apb register port
`timescale 1ns/100ps
`include "mhc_regs.svh"

// Operation
// RULE1 - host kicks the watchdog with falling edges, pulses wide, period bounded
// RULE2 - modem raises supervisory reset after missed kicks or low supply
// RULE3 - direction select 0 means transmit, 1 means receive
// RULE4 - modem returns to receive itself when transmit is held over 1s
// RULE5 - modem pulls carrier sense low while a valid signal is present
// RULE6 - host catches carrier sense on a falling-edge interrupt input
// RULE7 - host takes supervisory reset rising edge as top event and resets
// RULE8 - host serial out feeds modem transmit, modem receive feeds serial in
// RULE9 - host serial rate toward the modem stays at or below 1200 baud
// RULE10 - on a pc port rts drives direction and loops back as cts
// RULE11 - on a pc port dsr ties to dtr, ring indicator unconnected
// RULE12 - on a pc port external logic supplies a free-running kick clock
// RULE13 - receive retiming logic is reset after power-up before use
// RULE14 - host runs from the modem master clock, no crystal of its own
// RULE15 - carrier sense asserts and releases only after the detect hold time
// RULE16 - transmit data held 0 in receive mode removes carrier clamping
// RULE17 - kick period measured between falling edges, low time inside it
module mhc_host #(
	parameter int unsigned KICK_PER_CYC = `MHC_KICK_PER_CYC,
	parameter int unsigned BIT_CYC      = `MHC_BIT_CYC
) (
	input  wire logic              pclk,     // modem master clock [RULE14]
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              carrier_sense_low,
	input  wire logic              modem_reset,
	input  wire logic              serial_in_pin,
	output mhc_pkg::mhc_pins_t     modem_pins,
	output logic                   host_reset_req
);
	import mhc_pkg::*;

	// kick period and kick low time, both in clock cycles
	localparam logic [31:0] KICK_LAST = 32'(KICK_PER_CYC - 1);
	localparam logic [31:0] KICK_LOW  = 32'(`MHC_KICK_LOW_CYC);

	// register map, one aligned word each
	//   ctrl   rw  bit0 transmit mode, bit1 kick enable, bit2 unclamp
	//   status ro  bit0 carrier present, bit1 supervisory event (w1c)
	//              bit2 carrier event (w1c), bit3 transmit busy
	//              bit4 byte waiting, bit5 byte error (w1c)
	//              bit6 supervisory reset level
	//   txdata wo  bits 7:0 start one frame, dropped while busy
	//   rxdata ro  last byte received; reading it clears bit4
	// only the low bits of each word are used; the rest read as zero
	// and ignore writes, so the map can grow without breaking software
	// timing seen by software
	//   every transfer takes one wait state, reads and writes alike
	//   a supervisory rise forces ctrl back to its reset value, so the
	//   link returns to receive and kicking resumes at once
	//   a new byte overwrites an unread one: there is no receive queue

	// pin synchronisers: carrier, supervisory reset, receive data
	logic [2:0] sync_m_q, sync_m_d;
	logic [2:0] sync_s_q, sync_s_d;
	logic [2:0] sync_p_q, sync_p_d;
	logic       car_s, supv_s, rxd_s;

	// apb slave state
	logic        pready_q,  pready_d;
	logic        pslverr_q, pslverr_d;
	logic [31:0] prdata_q,  prdata_d;

	// control, status and data registers
	logic [`MHC_CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [`MHC_ST_W-1:0]   stat;
	logic                   supv_ev_q, supv_ev_d;
	logic                   car_ev_q,  car_ev_d;
	logic                   rx_val_q,  rx_val_d;
	logic                   rx_err_q,  rx_err_d;
	logic [7:0]             rx_dat_q,  rx_dat_d;
	logic                   tx_go_q,   tx_go_d;
	logic [7:0]             tx_dat_q,  tx_dat_d;
	logic                   hrr_q,     hrr_d;

	// kick generator and pin drivers
	logic [31:0] kick_cnt_q, kick_cnt_d;
	mhc_pins_t   pins_q,     pins_d;

	// uart side
	logic        u_txd;
	logic        u_busy;
	logic        u_rx_valid;
	mhc_rxbyte_t u_rx_byte;

	logic access, wr_fire, rd_fire, mapped;
	logic supv_rise, car_fall, tx_busy;

	// second stage outputs, the ones that logic reads apart from the third-stage edge taps
	assign car_s  = sync_s_q[0];
	assign supv_s = sync_s_q[1];
	assign rxd_s  = sync_s_q[2];

	// two flops per pin, third stage only for edge detection
	always_comb begin
		sync_m_d = {serial_in_pin, modem_reset, carrier_sense_low};
		sync_s_d = sync_m_q;
		sync_p_d = sync_s_q;
	end

	// receive retiming restarts from line idle after every reset [RULE13]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_m_q <= 3'h7;
			sync_s_q <= 3'h7;
			sync_p_q <= 3'h7;
		end else begin
			sync_m_q <= sync_m_d;
			sync_s_q <= sync_s_d;
			sync_p_q <= sync_p_d;
		end
	end

	// supervisory reset starts high at power-up; only a real rise counts
	assign supv_rise = supv_s & ~sync_p_q[1];        // [RULE7]
	assign car_fall  = ~car_s & sync_p_q[0];         // [RULE6]
	assign tx_busy   = u_busy | tx_go_q;

	// one wait state: pready rises in the second access cycle
	assign access  = psel & penable & pready_q;
	assign wr_fire = access & pwrite;
	assign rd_fire = access & ~pwrite;
	// an unmapped address answers with pslverr and has no effect
	assign mapped  = (paddr == `MHC_CTRL_OFS) || (paddr == `MHC_STAT_OFS) ||
	                 (paddr == `MHC_TXD_OFS)  || (paddr == `MHC_RXD_OFS);

	// status word, lsb first: carrier, events, busy, byte flags, level
	assign stat = {supv_s, rx_err_q, rx_val_q, tx_busy,
	               car_ev_q, supv_ev_q, ~car_s};

	// read mux and completion flags; read data is zero outside the
	// ready cycle, so a stale word never lingers on the bus
	// between transfers
	always_comb begin
		pready_d  = psel & penable & ~pready_q;
		pslverr_d = pready_d & ~mapped;
		prdata_d  = 32'h0;
		if (paddr == `MHC_CTRL_OFS) begin
			prdata_d = {{(32-`MHC_CTRL_W){1'b0}}, ctrl_q};
		end else if (paddr == `MHC_STAT_OFS) begin
			prdata_d = {{(32-`MHC_ST_W){1'b0}}, stat};
		end else if (paddr == `MHC_RXD_OFS) begin
			prdata_d = {24'h0, rx_dat_q};
		end
		if (!pready_d || pwrite) begin
			prdata_d = 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else begin
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
		end
	end

	// register writes, sticky events; a set always beats a clear
	always_comb begin
		ctrl_d    = ctrl_q;
		supv_ev_d = supv_ev_q;
		car_ev_d  = car_ev_q;
		rx_err_d  = rx_err_q;
		rx_val_d  = rx_val_q;
		rx_dat_d  = rx_dat_q;
		tx_go_d   = 1'b0;
		tx_dat_d  = tx_dat_q;
		hrr_d     = supv_rise;                       // [RULE7]
		if (wr_fire && paddr == `MHC_CTRL_OFS) begin
			ctrl_d = pwdata[`MHC_CTRL_W-1:0];
		end else if (wr_fire && paddr == `MHC_STAT_OFS) begin
			if (pwdata[`MHC_ST_SUPV]) supv_ev_d = 1'b0;
			if (pwdata[`MHC_ST_CAREVT]) car_ev_d = 1'b0;
			if (pwdata[`MHC_ST_RXERR]) rx_err_d = 1'b0;
		end else if (wr_fire && paddr == `MHC_TXD_OFS && !tx_busy) begin
			tx_go_d  = 1'b1;                         // byte dropped when busy
			tx_dat_d = pwdata[7:0];
		end
		if (rd_fire && paddr == `MHC_RXD_OFS) begin
			rx_val_d = 1'b0;
		end
		// a new byte wins over a read in the same cycle
		if (u_rx_valid) begin
			rx_val_d = 1'b1;
			rx_dat_d = u_rx_byte.data;
			if (u_rx_byte.err) rx_err_d = 1'b1;
		end
		if (car_fall) begin
			car_ev_d = 1'b1;                         // [RULE6]
		end
		if (supv_rise) begin
			supv_ev_d = 1'b1;
			ctrl_d    = `MHC_CTRL_RST;               // self-reset [RULE7]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// kicking on from reset so the watchdog is served at once
			ctrl_q    <= `MHC_CTRL_RST;
			supv_ev_q <= 1'b0;
			car_ev_q  <= 1'b0;
			rx_err_q  <= 1'b0;
			rx_val_q  <= 1'b0;
			rx_dat_q  <= 8'h0;
			tx_go_q   <= 1'b0;
			tx_dat_q  <= 8'h0;
			hrr_q     <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			supv_ev_q <= supv_ev_d;
			car_ev_q  <= car_ev_d;
			rx_err_q  <= rx_err_d;
			rx_val_q  <= rx_val_d;
			rx_dat_q  <= rx_dat_d;
			tx_go_q   <= tx_go_d;
			tx_dat_q  <= tx_dat_d;
			hrr_q     <= hrr_d;
		end
	end

	// kick generator, free running so no outside kick clock is needed
	// [RULE12]; a started period always runs to its end and the counter
	// then rests at its last value, so a disable never cuts a low pulse
	// short and a quick re-enable never gives a short period
	always_comb begin
		kick_cnt_d = kick_cnt_q;
		if (kick_cnt_q != KICK_LAST) begin
			kick_cnt_d = kick_cnt_q + 32'h1;         // [RULE17]
		end else if (ctrl_q[`MHC_CTRL_KICK]) begin
			kick_cnt_d = 32'h0;                      // next fall [RULE1]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kick_cnt_q <= KICK_LAST;
		end else begin
			kick_cnt_q <= kick_cnt_d;
		end
	end

	// pin drivers, all registered
	always_comb begin
		pins_d.kick_n  = ~(kick_cnt_d < KICK_LOW);  // [RULE1]
		// one control bit alone sets the direction [RULE10]
		pins_d.dir_sel = ~ctrl_q[`MHC_CTRL_TX];     // 0 selects transmit [RULE3]
		if (ctrl_q[`MHC_CTRL_TX]) begin
			pins_d.serial_out_pin = u_txd;           // [RULE8]
		end else begin
			// low in receive lets weak signals through unclamped
			pins_d.serial_out_pin = ~ctrl_q[`MHC_CTRL_UNCLAMP]; // [RULE16]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// every pin idles: receive, no kick, line high
			pins_q <= '{dir_sel: 1'b1, kick_n: 1'b1, serial_out_pin: 1'b1};
		end else begin
			pins_q <= pins_d;
		end
	end

	// byte serialiser; rate fixed by BIT_CYC [RULE9]
	// a fixed rate keeps the baud limit out of software's hands, at the
	// cost of a rebuild for another rate
	mhc_uart #(
		.BIT_CYC (BIT_CYC)
	) u_uart (
		.pclk     (pclk),
		.presetn  (presetn),
		.tx_start (tx_go_q),
		.tx_byte  (tx_dat_q),
		.rx_in    (rxd_s),                           // [RULE8]
		.txd      (u_txd),
		.tx_busy  (u_busy),
		.rx_valid (u_rx_valid),
		.rx_byte  (u_rx_byte)
	);

	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign modem_pins     = pins_q;
	assign host_reset_req = hrr_q;

endmodule : mhc_host

// [mhc_pkg_order_note_unused.sv]
// holds no logic: the controller lives in mhc_host.sv and mhc_uart.sv

// [mhc_properties.sv]
// port checker for the modem host controller, bound to mhc_host
`timescale 1ns/100ps
`include "mhc_regs.svh"
module mhc_properties #(
	parameter int unsigned KICK_PER_CYC = `MHC_KICK_PER_CYC,
	parameter int unsigned BIT_CYC      = `MHC_BIT_CYC
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic               modem_reset,
	input wire mhc_pkg::mhc_pins_t modem_pins,
	input wire logic               host_reset_req
);
	import mhc_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [31:0] low_q, per_q, bit_q;
	logic        seen_q;

	sequence s_access;
		psel && !penable ##1 psel && penable;
	endsequence

	// run lengths of kick low, kick period and serial level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_q  <= 32'h0;
			per_q  <= 32'h0;
			bit_q  <= 32'h0;
			seen_q <= 1'b0;
		end else begin
			low_q  <= modem_pins.kick_n ? 32'h0 : low_q + 32'h1;
			per_q  <= $fell(modem_pins.kick_n) ? 32'h0 : per_q + 32'h1;
			bit_q  <= $changed(modem_pins.serial_out_pin) ? 32'h0
				: bit_q + 32'h1;
			seen_q <= seen_q | $fell(modem_pins.kick_n);
		end
	end

	a_kick_width: assert property (
		$rose(modem_pins.kick_n) |-> low_q >= 32'(`MHC_KICK_LOW_CYC))
		else $error("kick pulse too short");
	a_kick_period: assert property (
		$fell(modem_pins.kick_n) && seen_q
		|-> per_q >= 32'(KICK_PER_CYC - 1))
		else $error("kick period too short");
	// only whole low levels inside transmit mode are timed
	a_bit_time: assert property (
		$rose(modem_pins.serial_out_pin) && !modem_pins.dir_sel
		&& !$past(modem_pins.dir_sel) |-> bit_q >= 32'(BIT_CYC - 1))
		else $error("serial bit too short");
	a_apb_wait: assert property (s_access |-> !pready ##1 pready)
		else $error("wait state count wrong");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error outside ready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
		else $error("read data outside ready");
	a_nmi_pulse: assert property (
		$rose(modem_reset) |-> ##[2:5] host_reset_req)
		else $error("supervisory rise not forwarded");
	a_nmi_single: assert property (
		host_reset_req |=> !host_reset_req)
		else $error("host reset pulse too long");
	a_nmi_receive: assert property (
		host_reset_req |-> ##[0:3] modem_pins.dir_sel)
		else $error("not back in receive");
endmodule : mhc_properties

bind mhc_host mhc_properties #(
	.KICK_PER_CYC(KICK_PER_CYC),
	.BIT_CYC(BIT_CYC)
) mhc_properties_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.modem_reset(modem_reset), .modem_pins(modem_pins),
	.host_reset_req(host_reset_req)
);

// [mhc_modem_model.sv]
// behavioural power line modem seen from the host pins
`timescale 1ns/100ps
module mhc_modem_model #(
	parameter int unsigned WD_CYC = 1000,
	parameter int unsigned HOLD   = 20,
	parameter int unsigned TX_MAX = 3000
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire mhc_pkg::mhc_pins_t modem_pins,
	input  wire logic               carrier_on,
	input  wire logic               supply_low,
	input  wire logic               rx_line,
	output logic                    carrier_sense_low,
	output logic                    modem_reset,
	output logic                    serial_in_pin
);
	import mhc_pkg::*;
	logic [15:0] wd_q, det_q, tx_q;
	logic        kick_q, rx_mode;

	// watchdog age, carrier hold timer, time spent in transmit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_q <= 16'h0000;
			det_q <= 16'h0000;
			tx_q <= 16'h0000;
			kick_q <= 1'b1;
			carrier_sense_low <= 1'b1;
		end else begin
			kick_q <= modem_pins.kick_n;
			wd_q <= (kick_q && !modem_pins.kick_n) ? 16'h0000
				: wd_q + {15'h0000, wd_q != 16'hFFFF};
			det_q <= (carrier_on != carrier_sense_low) ? 16'h0000
				: det_q + 16'h0001;
			if (det_q == 16'(HOLD - 1))
				carrier_sense_low <= !carrier_on;
			tx_q <= modem_pins.dir_sel ? 16'h0000
				: tx_q + {15'h0000, tx_q != 16'hFFFF};
		end
	end

	assign rx_mode = modem_pins.dir_sel || tx_q >= 16'(TX_MAX);
	assign modem_reset = (wd_q > 16'(WD_CYC)) || supply_low;
	// clamped high in transmit mode, or with no carrier unless transmit data holds 0
	assign serial_in_pin = (rx_mode && (!carrier_sense_low
		|| !modem_pins.serial_out_pin)) ? rx_line : 1'b1;
endmodule : mhc_modem_model

// [tb_top.sv]
// self-checking bench for the modem host controller
`timescale 1ns/100ps
module tb_top;
	import mhc_pkg::*;
	localparam int unsigned KP = 400;
	localparam int unsigned BC = 16;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        car_low, mreset, rxd_pin, hreq, carrier_on, rx_line;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	mhc_pins_t   pins;
	int          fail_count, num_checks, cyc;

	mhc_host #(.KICK_PER_CYC(KP), .BIT_CYC(BC)) mhc_host_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .carrier_sense_low(car_low),
		.modem_reset(mreset), .serial_in_pin(rxd_pin), .modem_pins(pins),
		.host_reset_req(hreq));
	mhc_modem_model mhc_modem_model_inst (
		.pclk(pclk), .presetn(presetn), .modem_pins(pins),
		.carrier_on(carrier_on), .supply_low(1'b0), .rx_line(rx_line),
		.carrier_sense_low(car_low), .modem_reset(mreset),
		.serial_in_pin(rxd_pin));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	// 250 MHz clock and a hang guard
	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one transfer; an idle edge after it keeps drivers apart
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rdc(input logic [7:0] a, input logic [31:0] m, e,
		input string nm);
		apb(1'b0, a, 32'h00000000);
		chk(nm, rd & m, e);
	endtask : rdc

	task automatic t_regs();
		rdc(8'h00, 32'hFFFFFFFF, 32'h00000002, "ctrl reset");
		rdc(8'h04, 32'h0000007F, 32'h00000000, "status reset");
		apb(1'b1, 8'h10, 32'h00000007);
		rdc(8'h10, 32'hFFFFFFFF, 32'h00000000, "unmapped read");
		chk("slverr", {31'h0, err}, 32'h00000001);
	endtask : t_regs

	// sampled kick low time and fall-to-fall period
	task automatic t_kick();
		int lo, hi;
		lo = 0;
		hi = 0;
		// skip a pulse already under way so only whole pulses are timed
		while (pins.kick_n !== 1'b1) @(posedge pclk);
		while (pins.kick_n !== 1'b0) @(posedge pclk);
		while (pins.kick_n === 1'b0) begin
			@(posedge pclk);
			lo++;
		end
		while (pins.kick_n === 1'b1) begin
			@(posedge pclk);
			hi++;
		end
		chk("kick low", 32'(lo), 32'h0000007D);
		chk("kick period", 32'(lo + hi), 32'(KP));
	endtask : t_kick

	// one frame sampled mid-bit; a write while busy must be dropped
	task automatic t_tx(input logic [7:0] d);
		logic [10:0] f;
		apb(1'b1, 8'h00, 32'h00000003);
		repeat (2) @(posedge pclk);
		chk("dir", {31'h0, pins.dir_sel}, 32'h00000000);
		apb(1'b1, 8'h08, {24'h0, d});
		apb(1'b1, 8'h08, 32'h0000005A);
		while (pins.serial_out_pin !== 1'b0) @(posedge pclk);
		repeat (BC / 2) @(posedge pclk);
		for (int i = 0; i < 11; i++) begin
			f[i] = pins.serial_out_pin;
			repeat (BC) @(posedge pclk);
		end
		chk("frame", {21'h0, f}, {21'h0, 1'b1, ~^d, d, 1'b0});
		repeat (BC) @(posedge pclk);
		chk("dropped", {31'h0, pins.serial_out_pin}, 32'h00000001);
		apb(1'b1, 8'h00, 32'h00000002);
	endtask : t_tx

	task automatic t_carrier();
		carrier_on <= 1'b1;
		while (car_low !== 1'b0) @(posedge pclk);
		repeat (4) @(posedge pclk);
		rdc(8'h04, 32'h00000005, 32'h00000005, "carrier");
		apb(1'b1, 8'h04, 32'h00000004);
		rdc(8'h04, 32'h00000005, 32'h00000001, "event clear");
	endtask : t_carrier

	// a frame on the line under a carrier, clamp and parity setting
	task automatic t_rx(input logic c, u, bad, input logic [7:0] d,
		input logic [1:0] st, m);
		logic [10:0] f;
		f = {1'b1, ~^d ^ bad, d, 1'b0};
		carrier_on <= c;
		apb(1'b1, 8'h00, {29'h0, u, 2'b10});
		while (car_low !== !c) @(posedge pclk);
		for (int i = 0; i < 11; i++) begin
			rx_line <= f[i];
			repeat (BC) @(posedge pclk);
		end
		repeat (8) @(posedge pclk);
		rdc(8'h04, {26'h0, m, 4'h0}, {26'h0, st, 4'h0}, "rx st");
		apb(1'b0, 8'h0C, 32'h00000000);
		if (st[0])
			chk("rx byte", rd & 32'hFF, {24'h0, d});
		apb(1'b1, 8'h04, 32'h00000020);
	endtask : t_rx

	// kicks stop; the supervisory reset returns as a host reset
	task automatic t_supv();
		logic held;
		held = 1'b1;
		// transmit mode with kicks off, so the return to receive shows
		apb(1'b1, 8'h00, 32'h00000001);
		repeat (KP) @(posedge pclk);
		while (hreq !== 1'b1) begin
			held &= pins.kick_n;
			@(posedge pclk);
		end
		chk("kick off", {31'h0, held}, 32'h00000001);
		rdc(8'h00, 32'hFFFFFFFF, 32'h00000002, "ctrl back");
		rdc(8'h04, 32'h00000002, 32'h00000002, "supv");
		while (mreset !== 1'b0) @(posedge pclk);
		repeat (4) @(posedge pclk);
		apb(1'b1, 8'h04, 32'h00000002);
		rdc(8'h04, 32'h00000002, 32'h00000000, "supv clr");
	endtask : t_supv

	initial begin
		{pclk, presetn, psel, penable, pwrite, carrier_on} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		rx_line = 1'b1;
		repeat (16) @(posedge pclk);
		chk("reset pins", {29'h0, pins}, 32'h00000007);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_kick();
		t_tx(8'hA5);
		t_carrier();
		t_rx(1'b1, 1'b0, 1'b0, 8'h3C, 2'b01, 2'b11);
		t_rx(1'b0, 1'b0, 1'b0, 8'hC3, 2'b00, 2'b11);
		t_rx(1'b0, 1'b1, 1'b0, 8'h96, 2'b01, 2'b11);
		t_rx(1'b0, 1'b1, 1'b1, 8'h55, 2'b10, 2'b10);
		t_supv();
		wrap_up();
	end
endmodule : tb_top
